// ### src/usbev_map.vh
// Constants for the USB event flag and interrupt enable block.
// Assumes a 32-bit AXI4-Lite register bus with one register per aligned word.
// Summary of operation
// - Hardware sets flags; writing one clears them.
// - Flag interrupts only when its enable bit set.
// - Bit 0 set on setup while buffer full.
// - Bit 2 set on every received setup.
// - Setup flag forces endpoint 0 NAK both ways.
// - Bit 3 set on port power-on request.
// - Bit 4 set on port power-off request.
// - Bit 5 set when resume is detected.
// - Bit 6 set on global or selective suspend.
// - Bit 7 set when host drives port reset.
// - Enable bits read/write, same positions, reset zero.
// - Endpoint 0 count registers hold NAK bit 7.
`ifndef USBEV_MAP_VH
`define USBEV_MAP_VH

`define USBEV_ADDR_W          8
`define USBEV_OFS_FLAGS       8'h00
`define USBEV_OFS_ENABLE      8'h04
`define USBEV_OFS_IN0_COUNT   8'h08
`define USBEV_OFS_OUT0_COUNT  8'h0C
`define USBEV_OFS_EP0_STATE   8'h10

`define USBEV_BIT_SETUP_OVERWRITE_FLAG_OVR   0
`define USBEV_BIT_RESERVED    1
`define USBEV_BIT_SETUP       2
`define USBEV_BIT_PWR_ON      3
`define USBEV_BIT_PWR_OFF     4
`define USBEV_BIT_RESUME      5
`define USBEV_BIT_SUSPEND     6
`define USBEV_BIT_BUS_RESET   7
`define USBEV_FLAG_VALID_MASK 8'hFD

`define USBEV_BIT_NAK         7
`define USBEV_COUNT_W         4

`define USBEV_RST_FLAGS       8'h00
`define USBEV_RST_ENABLE      8'h00
`define USBEV_RST_IN0_COUNT   8'h80
`define USBEV_RST_OUT0_COUNT  8'h80

`define USBEV_RESP_OKAY       2'b00
`define USBEV_RESP_SLVERR     2'b10

`endif

// ### src/usbev_axi_slave.v
// AXI4-Lite slave handshake engine for the USB event block.
// Assumes the parent decodes addresses and supplies read data combinationally.
`timescale 1ns/1ps
`include "usbev_map.vh"

module usbev_axi_slave #(
  parameter ADDR_W = `USBEV_ADDR_W
) (
  input  wire              core_clk,
  input  wire              rst,
  input  wire [ADDR_W-1:0] s_axi_awaddr,
  input  wire              s_axi_awvalid,
  output reg               s_axi_awready,
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output reg               s_axi_wready,
  output reg  [1:0]        s_axi_bresp,
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  input  wire [ADDR_W-1:0] s_axi_araddr,
  input  wire              s_axi_arvalid,
  output reg               s_axi_arready,
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready,
  output wire              wrPulse,
  output wire [ADDR_W-1:0] wrAddr,
  output wire [31:0]       wrData,
  output wire [3:0]        wrStrb,
  input  wire              wrHit,
  output wire              rdPulse,
  output wire [ADDR_W-1:0] rdAddr,
  input  wire [31:0]       rdData,
  input  wire              rdHit
);

  reg              awFull_r;
  reg              wFull_r;
  reg [ADDR_W-1:0] awAddr_r;
  reg [31:0]       wData_r;
  reg [3:0]        wStrb_r;
  wire             awTake;
  wire             wTake;
  wire             awFull_nxt;
  wire             wFull_nxt;
  wire             bvalid_nxt;
  wire             rvalid_nxt;

  // Address and data are captured separately; the write fires once both are held.
  assign awTake     = s_axi_awvalid & s_axi_awready;
  assign wTake      = s_axi_wvalid & s_axi_wready;
  assign wrPulse    = awFull_r & wFull_r & ~s_axi_bvalid;
  assign wrAddr     = awAddr_r;
  assign wrData     = wData_r;
  assign wrStrb     = wStrb_r;
  assign awFull_nxt = wrPulse ? 1'b0 : (awFull_r | awTake);
  assign wFull_nxt  = wrPulse ? 1'b0 : (wFull_r | wTake);
  assign bvalid_nxt = wrPulse | (s_axi_bvalid & ~s_axi_bready);

  // A read is taken and served in one step; data is latched at the taking edge.
  assign rdPulse    = s_axi_arvalid & s_axi_arready;
  assign rdAddr     = s_axi_araddr;
  assign rvalid_nxt = rdPulse | (s_axi_rvalid & ~s_axi_rready);

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      awFull_r      <= 1'b0;
      wFull_r       <= 1'b0;
      awAddr_r      <= {ADDR_W{1'b0}};
      wData_r       <= 32'h00000000;
      wStrb_r       <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `USBEV_RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `USBEV_RESP_OKAY;
    end else begin
      awFull_r      <= awFull_nxt;
      wFull_r       <= wFull_nxt;
      s_axi_awready <= ~awFull_nxt & ~bvalid_nxt;
      s_axi_wready  <= ~wFull_nxt & ~bvalid_nxt;
      s_axi_bvalid  <= bvalid_nxt;
      s_axi_arready <= ~rvalid_nxt;
      s_axi_rvalid  <= rvalid_nxt;
      if (awTake) begin
        awAddr_r <= s_axi_awaddr;
      end
      if (wTake) begin
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
      end
      if (wrPulse) begin
        s_axi_bresp <= wrHit ? `USBEV_RESP_OKAY : `USBEV_RESP_SLVERR;
      end
      if (rdPulse) begin
        s_axi_rdata <= rdData;
        s_axi_rresp <= rdHit ? `USBEV_RESP_OKAY : `USBEV_RESP_SLVERR;
      end
    end
  end

endmodule

// ### src/usbev_event_status.v
// USB function event flags, interrupt enables and endpoint 0 NAK control.
// Assumes event pulses come from the USB engine on core_clk; registers sit on AXI4-Lite.
`timescale 1ns/1ps
`include "usbev_map.vh"

module usbev_event_status #(
  parameter ADDR_W  = `USBEV_ADDR_W,
  parameter COUNT_W = `USBEV_COUNT_W
) (
  input  wire               core_clk,
  input  wire               rst,
  input  wire [ADDR_W-1:0]  s_axi_awaddr,
  input  wire               s_axi_awvalid,
  output wire               s_axi_awready,
  input  wire [31:0]        s_axi_wdata,
  input  wire [3:0]         s_axi_wstrb,
  input  wire               s_axi_wvalid,
  output wire               s_axi_wready,
  output wire [1:0]         s_axi_bresp,
  output wire               s_axi_bvalid,
  input  wire               s_axi_bready,
  input  wire [ADDR_W-1:0]  s_axi_araddr,
  input  wire               s_axi_arvalid,
  output wire               s_axi_arready,
  output wire [31:0]        s_axi_rdata,
  output wire [1:0]         s_axi_rresp,
  output wire               s_axi_rvalid,
  input  wire               s_axi_rready,
  input  wire               setupRcvd,
  input  wire               powerOnReq,
  input  wire               powerOffReq,
  input  wire               resumeDet,
  input  wire               globalSuspendDet,
  input  wire               selectiveSuspendDet,
  input  wire               busResetDet,
  input  wire               ep0InSent,
  input  wire               ep0OutRcvd,
  input  wire [COUNT_W-1:0] ep0OutRcvdCount,
  output reg                usbIrq,
  output reg                ep0InNak,
  output reg                ep0OutNak,
  output reg  [COUNT_W-1:0] ep0InCount,
  output reg                setupPending
);

  wire              wrPulse;
  wire [ADDR_W-1:0] wrAddr;
  wire [31:0]       wrData;
  wire [3:0]        wrStrb;
  wire              rdPulse;
  wire [ADDR_W-1:0] rdAddr;
  reg  [31:0]       rdData;
  reg               rdHit;
  reg               wrHit;

  reg  [7:0]        usb_event_flags_r;
  wire [7:0]        usb_event_flags_nxt;
  reg  [7:0]        usb_event_interrupt_enable_r;
  wire [7:0]        usb_event_interrupt_enable_nxt;
  reg  [7:0]        in0Count_r;
  reg  [7:0]        in0Count_nxt;
  reg  [7:0]        out0Count_r;
  reg  [7:0]        out0Count_nxt;

  wire [7:0]        eventSet;
  wire [7:0]        eventClr;
  wire              lane0Write;
  wire              flagsWrite;
  wire              enableWrite;
  wire              in0Write;
  wire              out0Write;
  wire              flagsRead;
  wire              irq_nxt;
  wire              inNak_nxt;
  wire              outNak_nxt;

  usbev_axi_slave #(
    .ADDR_W (ADDR_W)
  ) u_bus (
    .core_clk      (core_clk),
    .rst           (rst),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .wrPulse       (wrPulse),
    .wrAddr        (wrAddr),
    .wrData        (wrData),
    .wrStrb        (wrStrb),
    .wrHit         (wrHit),
    .rdPulse       (rdPulse),
    .rdAddr        (rdAddr),
    .rdData        (rdData),
    .rdHit         (rdHit)
  );

  // Write decode; every register lives in byte lane 0.
  assign lane0Write  = wrPulse & wrStrb[0];
  assign flagsWrite  = lane0Write & (wrAddr == `USBEV_OFS_FLAGS);
  assign enableWrite = lane0Write & (wrAddr == `USBEV_OFS_ENABLE);
  assign in0Write    = lane0Write & (wrAddr == `USBEV_OFS_IN0_COUNT);
  assign out0Write   = lane0Write & (wrAddr == `USBEV_OFS_OUT0_COUNT);
  assign flagsRead   = rdPulse & (rdAddr == `USBEV_OFS_FLAGS);

  always @* begin
    case (wrAddr)
      `USBEV_OFS_FLAGS:     wrHit = 1'b1;
      `USBEV_OFS_ENABLE:    wrHit = 1'b1;
      `USBEV_OFS_IN0_COUNT: wrHit = 1'b1;
      `USBEV_OFS_OUT0_COUNT: wrHit = 1'b1;
      `USBEV_OFS_EP0_STATE: wrHit = 1'b1;
      default:              wrHit = 1'b0;
    endcase
  end

  // Hardware event sources, one per flag position.
  assign eventSet[`USBEV_BIT_SETUP_OVERWRITE_FLAG_OVR] = setupRcvd & usb_event_flags_r[`USBEV_BIT_SETUP];
  assign eventSet[`USBEV_BIT_RESERVED]  = 1'b0;
  assign eventSet[`USBEV_BIT_SETUP]     = setupRcvd;
  assign eventSet[`USBEV_BIT_PWR_ON]    = powerOnReq;
  assign eventSet[`USBEV_BIT_PWR_OFF]   = powerOffReq;
  assign eventSet[`USBEV_BIT_RESUME]    = resumeDet;
  assign eventSet[`USBEV_BIT_SUSPEND]   = globalSuspendDet | selectiveSuspendDet;
  assign eventSet[`USBEV_BIT_BUS_RESET] = busResetDet;

  // Clears come from writing ones or from reading the flag register.
  assign eventClr = (flagsWrite ? wrData[7:0] : 8'h00) | (flagsRead ? 8'hFF : 8'h00);

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_flag
      if (gi == `USBEV_BIT_RESERVED) begin : g_rsv
        assign usb_event_flags_nxt[gi] = 1'b0;
      end else begin : g_live
        // A set in the same cycle as a clear keeps the flag.
        assign usb_event_flags_nxt[gi] = eventSet[gi] | (usb_event_flags_r[gi] & ~eventClr[gi]);
      end
    end
  endgenerate

  // Interrupt is the OR of enabled flags, taken from the next state of both registers.
  assign usb_event_interrupt_enable_nxt = enableWrite ? (wrData[7:0] & `USBEV_FLAG_VALID_MASK)
                                                      : usb_event_interrupt_enable_r;
  assign irq_nxt = |(usb_event_flags_nxt & usb_event_interrupt_enable_nxt);

  // Endpoint 0 count registers with their NAK bits.
  always @* begin
    in0Count_nxt  = in0Count_r;
    out0Count_nxt = out0Count_r;
    if (in0Write) begin
      in0Count_nxt = {wrData[`USBEV_BIT_NAK], 3'b000, wrData[COUNT_W-1:0]};
    end
    if (ep0InSent) begin
      in0Count_nxt[`USBEV_BIT_NAK] = 1'b1;
    end
    if (out0Write) begin
      out0Count_nxt = {wrData[`USBEV_BIT_NAK], 3'b000, wrData[COUNT_W-1:0]};
    end
    if (ep0OutRcvd) begin
      out0Count_nxt = {1'b1, 3'b000, ep0OutRcvdCount};
    end
  end

  // The setup flag overrides the endpoint's own NAK bits in both directions.
  assign inNak_nxt  = in0Count_nxt[`USBEV_BIT_NAK] | usb_event_flags_nxt[`USBEV_BIT_SETUP];
  assign outNak_nxt = out0Count_nxt[`USBEV_BIT_NAK] | usb_event_flags_nxt[`USBEV_BIT_SETUP];

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      usb_event_flags_r            <= `USBEV_RST_FLAGS;
      usb_event_interrupt_enable_r <= `USBEV_RST_ENABLE;
      in0Count_r                   <= `USBEV_RST_IN0_COUNT;
      out0Count_r                  <= `USBEV_RST_OUT0_COUNT;
      usbIrq                       <= 1'b0;
      ep0InNak                     <= 1'b1;
      ep0OutNak                    <= 1'b1;
      ep0InCount                   <= {COUNT_W{1'b0}};
      setupPending                 <= 1'b0;
    end else begin
      usb_event_flags_r <= usb_event_flags_nxt;
      usb_event_interrupt_enable_r <= usb_event_interrupt_enable_nxt;
      in0Count_r   <= in0Count_nxt;
      out0Count_r  <= out0Count_nxt;
      usbIrq       <= irq_nxt;
      ep0InNak     <= inNak_nxt;
      ep0OutNak    <= outNak_nxt;
      ep0InCount   <= in0Count_nxt[COUNT_W-1:0];
      setupPending <= usb_event_flags_nxt[`USBEV_BIT_SETUP];
    end
  end

  // Read decode; unused upper bits read as zero.
  always @* begin
    rdData = 32'h00000000;
    rdHit  = 1'b1;
    case (rdAddr)
      `USBEV_OFS_FLAGS: begin
        rdData[7:0] = usb_event_flags_r;
      end
      `USBEV_OFS_ENABLE: begin
        rdData[7:0] = usb_event_interrupt_enable_r;
      end
      `USBEV_OFS_IN0_COUNT: begin
        rdData[7:0] = in0Count_r;
      end
      `USBEV_OFS_OUT0_COUNT: begin
        rdData[7:0] = out0Count_r;
      end
      `USBEV_OFS_EP0_STATE: begin
        rdData[2:0] = {usbIrq, ep0OutNak, ep0InNak};
      end
      default: begin
        rdHit = 1'b0;
      end
    endcase
  end

endmodule

// ### testbench/usbev_event_status_asserts.sv
// Checker for the USB event block: handshakes, NAK override and interrupt clear timing.
// Assumes it is bound to usbev_event_status and sees only its ports.
`timescale 1ns/1ps

module usbev_event_status_asserts (
  input logic core_clk,
  input logic rst,
  input logic s_axi_awvalid,
  input logic s_axi_awready,
  input logic s_axi_wvalid,
  input logic s_axi_wready,
  input logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic s_axi_arvalid,
  input logic s_axi_arready,
  input logic s_axi_rvalid,
  input logic setupRcvd,
  input logic ep0InSent,
  input logic ep0OutRcvd,
  input logic usbIrq,
  input logic ep0InNak,
  input logic ep0OutNak,
  input logic setupPending
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  property p_setupSets; setupRcvd |=> setupPending; endproperty
  a_setupSets: assert property (p_setupSets)
    else $error("setup flag not set");
  property p_nakForce; setupPending |-> ep0InNak && ep0OutNak; endproperty
  a_nakForce: assert property (p_nakForce)
    else $error("endpoint 0 not forced to NAK");
  property p_inNak; ep0InSent |=> ep0InNak; endproperty
  a_inNak: assert property (p_inNak)
    else $error("IN NAK not set after send");
  property p_outNak; ep0OutRcvd |=> ep0OutNak; endproperty
  a_outNak: assert property (p_outNak)
    else $error("OUT NAK not set after receive");
  property p_irqFall; $fell(usbIrq) |-> $rose(s_axi_bvalid) || $past(s_axi_arvalid && s_axi_arready); endproperty
  a_irqFall: assert property (p_irqFall)
    else $error("interrupt dropped without software access");
  property p_wrAnswer; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid; endproperty
  a_wrAnswer: assert property (p_wrAnswer)
    else $error("write response late");
  property p_rdAnswer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rdAnswer: assert property (p_rdAnswer)
    else $error("read data late");
  property p_arBlock; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_arBlock: assert property (p_arBlock)
    else $error("read address taken while data pending");
  property p_bOnce; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
  a_bOnce: assert property (p_bOnce)
    else $error("write response repeated");
  c_setup: cover property ($rose(setupPending));
  c_irq: cover property ($rose(usbIrq));
  c_irqFall: cover property ($fell(usbIrq));
endmodule

bind usbev_event_status usbev_event_status_asserts usbev_event_status_asserts_i (.core_clk, .rst, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .setupRcvd, .ep0InSent, .ep0OutRcvd, .usbIrq, .ep0InNak, .ep0OutNak, .setupPending);

// ### testbench/usbev_event_status_tb_top.sv
// Self-checking bench for the USB event block: random events, clears, masks and EP0 NAK.
// Assumes usbev_event_status and usbev_map.vh on the include path.
`timescale 1ns/1ps
`include "usbev_map.vh"

module usbev_event_status_tb_top;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  logic        setupRcvd = 0, powerOnReq = 0, powerOffReq = 0, resumeDet = 0, globalSuspendDet = 0;
  logic        selectiveSuspendDet = 0, busResetDet = 0, ep0InSent = 0, ep0OutRcvd = 0;
  logic [3:0]  ep0OutRcvdCount = 4'h0;
  wire         usbIrq, ep0InNak, ep0OutNak, setupPending;
  wire  [3:0]  ep0InCount;
  logic [31:0] seed = 32'hF5D8, d;
  logic [1:0]  r;
  logic [7:0]  expF = 8'h00, expE = 8'h00;
  logic        inNak = 1'b1;
  int          miscompares = 0, nChecks = 0;

  always #25 core_clk = ~core_clk;

  usbev_event_status usbev_event_status_i (.core_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .setupRcvd, .powerOnReq, .powerOffReq, .resumeDet, .globalSuspendDet, .selectiveSuspendDet, .busResetDet,
    .ep0InSent, .ep0OutRcvd, .ep0OutRcvdCount, .usbIrq, .ep0InNak, .ep0OutNak, .ep0InCount, .setupPending);

  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction

  // Bit 1 of an event vector stands for selective suspend, which lands in flag bit 6.
  function automatic logic [7:0] nextFlags(input logic [7:0] cur, input logic [7:0] e);
    logic [7:0] f;
    f = cur | (e & 8'hFC);
    f[6] = f[6] | e[1];
    f[0] = f[0] | (e[2] & cur[2]);
    return f;
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    nChecks++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic pulse(input logic [7:0] e);
    @(posedge core_clk);
    {busResetDet, globalSuspendDet, resumeDet, powerOffReq, powerOnReq, setupRcvd, selectiveSuspendDet} <= e[7:1];
    @(posedge core_clk);
    {busResetDet, globalSuspendDet, resumeDet, powerOffReq, powerOnReq, setupRcvd, selectiveSuspendDet} <= 7'h00;
    expF = nextFlags(expF, e);
    #1;
  endtask

  // Flag read with resume reported at the taking edge: the set must survive the read clear.
  task automatic rdSetRace;
    @(posedge core_clk);
    s_axi_araddr <= `USBEV_OFS_FLAGS;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    resumeDet <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_arready) begin
        s_axi_arvalid <= 1'b0;
        resumeDet <= 1'b0;
      end
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    expF = 8'h20;
  endtask

  task automatic chkOut;
    chk("usbIrq", |(expF & expE), usbIrq);
    chk("setupPending", expF[2], setupPending);
    chk("ep0InNak", inNak | expF[2], ep0InNak);
  endtask

  task automatic rdFlags;
    rd(`USBEV_OFS_FLAGS);
    chk("flags", expF, d);
    expF = 8'h00;
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", nChecks, miscompares);
    if (miscompares == 0 && nChecks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // The whole sequence needs about 400 cycles; this allows 15000, over thirty times that.
  initial begin
    #750000;
    miscompares++;
    report_and_stop;
  end

  initial begin
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    rdFlags;
    rd(`USBEV_OFS_ENABLE);
    chk("enableRst", 32'h0, d);
    rd(`USBEV_OFS_IN0_COUNT);
    chk("inCountRst", 32'h80, d);
    chkOut;
    wr(`USBEV_OFS_ENABLE, 32'hFFFFFFFF);
    rd(`USBEV_OFS_ENABLE);
    chk("enableRw", 32'hFD, d);
    expE = 8'hFD;
    for (int i = 1; i < 8; i++) begin
      pulse(8'h01 << i);
      chkOut;
      rdFlags;
    end
    pulse(8'h04);
    pulse(8'h04);
    rd(`USBEV_OFS_FLAGS);
    chk("overwrite", 32'h05, d);
    expF = 8'h00;
    rdFlags;
    pulse(8'hFE);
    wr(`USBEV_OFS_ENABLE, 32'h08);
    expE = 8'h08;
    wr(`USBEV_OFS_FLAGS, 32'h00);
    chkOut;
    wr(`USBEV_OFS_FLAGS, 32'h08);
    expF[3] = 1'b0;
    chkOut;
    wr(`USBEV_OFS_ENABLE, 32'hFD);
    expE = 8'hFD;
    chkOut;
    rdFlags;
    for (int i = 0; i < 80; i++) begin
      seed = xs(seed);
      case (seed[9:8])
        2'd0: pulse(seed[7:0] & 8'hFE);
        2'd1: begin
          wr(`USBEV_OFS_ENABLE, seed);
          expE = seed[7:0] & 8'hFD;
        end
        2'd2: begin
          wr(`USBEV_OFS_FLAGS, seed);
          expF = expF & ~seed[7:0];
        end
        default: rdFlags;
      endcase
      chkOut;
    end
    rdFlags;
    rdSetRace;
    chkOut;
    rdFlags;
    pulse(8'h04);
    wr(`USBEV_OFS_IN0_COUNT, 32'h05);
    inNak = 1'b0;
    chkOut;
    chk("inCount", 4'h5, ep0InCount);
    wr(`USBEV_OFS_FLAGS, 32'h04);
    expF[2] = 1'b0;
    chkOut;
    @(posedge core_clk);
    ep0InSent <= 1'b1;
    @(posedge core_clk);
    ep0InSent <= 1'b0;
    inNak = 1'b1;
    rd(`USBEV_OFS_IN0_COUNT);
    chk("inCountNak", 32'h85, d);
    wr(`USBEV_OFS_OUT0_COUNT, 32'h00);
    chk("outNakOff", 1'b0, ep0OutNak);
    @(posedge core_clk);
    ep0OutRcvdCount <= 4'hA;
    ep0OutRcvd <= 1'b1;
    @(posedge core_clk);
    ep0OutRcvd <= 1'b0;
    rd(`USBEV_OFS_OUT0_COUNT);
    chk("outCount", 32'h8A, d);
    wr(8'h20, 32'hFF);
    chk("wrErr", `USBEV_RESP_SLVERR, r);
    rd(8'h20);
    chk("rdErr", `USBEV_RESP_SLVERR, r);
    chk("rdErrData", 32'h0, d);
    report_and_stop;
  end
endmodule
